// [hw/fsc_pkg.sv]
// constants for the frame sequencer configuration bank
// assumes a 32-bit ahb-lite bus; each register is one word at 4 * index
package fsc_pkg;
	localparam int FSC_NREG = 15;
	localparam logic [3:0] IDX_GENERAL = 4'h0;
	localparam logic [3:0] IDX_READOUT = 4'h1;
	localparam logic [3:0] IDX_INTEG = 4'h2;
	localparam logic [3:0] IDX_REGION = 4'h3;
	localparam logic [3:0] IDX_SPARE = 4'h4;
	localparam logic [3:0] IDX_DARK = 4'h5;
	localparam logic [3:0] IDX_FILLER = 4'h6;
	localparam logic [3:0] IDX_TICK = 4'h7;
	localparam logic [3:0] IDX_PERIOD = 4'h8;
	localparam logic [3:0] IDX_EXP = 4'h9;
	localparam logic [3:0] IDX_EXP2 = 4'hA;
	localparam logic [3:0] IDX_EXP3 = 4'hB;
	localparam logic [3:0] IDX_GAIN = 4'hC;
	localparam logic [3:0] IDX_FINE = 4'hD;
	localparam logic [3:0] IDX_SYNC = 4'hE;
	localparam logic [3:0] IDX_STATUS = 4'hF;
	// reset values by index
	localparam logic [15:0] FSC_RST [0:14] = '{16'h0000, 16'h0000,
		16'h0004, 16'h0001, 16'h0000, 16'h0102, 16'h0000, 16'h0001,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h01E2, 16'h0080,
		16'h033F};
	// writable bits by index; the rest read as zero
	localparam logic [15:0] FSC_MASK [0:14] = '{16'h3DF3, 16'hFFFF,
		16'h0007, 16'h00FF, 16'h0000, 16'h01FF, 16'h0FFF, 16'hFFFF,
		16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h21E3, 16'h0FFF,
		16'h073F};
	// general setup fields
	localparam int GEN_ENABLE = 0;
	localparam int GEN_ROLLING = 1;
	localparam int GEN_TRIGGERED = 4;
	localparam int GEN_SLAVE = 5;
	localparam int GEN_GAP_EN = 6;
	localparam int GEN_SUBSAMPLE = 7;
	localparam int GEN_BINNING = 8;
	localparam int GEN_STATS_WIN = 10;
	localparam int GEN_MON_LSB = 11;
	// integration setup fields
	localparam int INT_TWO_KNEE = 0;
	localparam int INT_THREE_KNEE = 1;
	localparam int INT_PERIOD_SEL = 2;
	// dark row and filler row setup fields
	localparam int DARK_BLANK = 8;
	localparam logic [7:0] DARK_MIN = 8'h01;
	localparam logic [11:0] FILLER_MAX = 12'h7FF;
	// gain fields
	localparam int GAIN_LAT_COMP = 13;
	// update timing fields and bus word size
	localparam int SYNC_LINE = 0;
	localparam int SYNC_DARK = 1;
	localparam int SYNC_FILLER = 2;
	localparam int SYNC_EXP = 3;
	localparam int SYNC_GAIN = 4;
	localparam int SYNC_REGION = 5;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// [hw/fsc_regs.sv]
// frame sequencer configuration register bank behind an ahb-lite slave
// assumes the sequencer pulses frame_start once per frame, synchronous
// What this block does
// - gap inserted only when gap enable set
// - gap length from 8-bit field when enabled
// - subsampling select, 0 full, resets 0
// - binning select, 0 none, resets 0
// - statistics window enable picks window subsampling
// - 3-bit select drives monitor pins
// - line extension pads rolling-shutter lines
// - knee enables act in global shutter only
// - period select: 0 reset, 1 frame; resets 1
// - dark rows 1 to 255, resets 2
// - first row blanking, resets 1
// - filler rows 0 to 2047, rolling only
// - tick divider in clocks, resets 1
// - period length used in global shutter only
// - exposure in lines rolling, ticks global
// - knee exposures ignored in rolling shutter
// - latency compensation defers synced gain one frame
// - sync bits defer updates to frame start
// - shutter select 0 global, 1 rolling
`timescale 1ns/1ps
module fsc_regs (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// sequencer timing
	input wire logic frame_start,
	// general setup
	output logic seq_enable,
	output logic rolling_shutter_mode,
	output logic triggered_mode,
	output logic slave_mode,
	output logic [7:0] readout_gap_cycles,
	output logic subsampling_select,
	output logic binning_select,
	output logic exposure_stats_window_enable,
	output logic [2:0] monitor_pin_select,
	output logic [2:0] monitor_pins,
	// row and frame shape
	output logic [7:0] rolling_line_extension,
	output logic [7:0] active_region_select,
	output logic [7:0] dark_row_count,
	output logic first_row_blanking,
	output logic [11:0] filler_row_count,
	// integration
	output logic two_knee_enable,
	output logic three_knee_enable,
	output logic period_interpretation_select,
	output logic [15:0] exposure_tick_divider,
	output logic [15:0] period_length,
	output logic [15:0] exposure_time,
	output logic exposure_in_lines,
	output logic [15:0] second_knee_exposure,
	output logic [15:0] third_knee_exposure,
	// gain
	output logic [1:0] analog_gain_first,
	output logic [3:0] analog_gain_second,
	output logic [11:0] fine_digital_gain
);
	import fsc_pkg::*;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	function automatic logic addr_ok(input logic [31:0] a);
		addr_ok = (a[31:6] == 26'h0) && (a[1:0] == 2'h0);
	endfunction

	// bus state
	logic wr_q, wr_d, rd_q, rd_d, ok_q, ok_d, ready_q, ready_d;
	logic [3:0] idx_q, idx_d;
	logic [31:0] rdata_q, rdata_d;
	logic accept, do_write;
	logic [15:0] status_w;
	logic [15:0] wval;

	// programmed and active values
	logic [15:0] cfg_q [0:14];
	logic [15:0] cfg_d [0:14];
	logic [7:0] act_line_q, act_line_d, act_roi_q, act_roi_d;
	logic [8:0] act_dark_q, act_dark_d;
	logic [11:0] act_fill_q, act_fill_d;
	logic [15:0] act_exp_q [0:2];
	logic [15:0] act_exp_d [0:2];
	logic [17:0] act_gain_q, act_gain_d;
	logic gain_pend_q, gain_pend_d, gain_wait_q, gain_wait_d;
	logic [17:0] prog_gain;
	logic rolling;

	assign accept = hsel && htrans[1] && hready;
	assign do_write = wr_q && ok_q && (idx_q < IDX_STATUS);
	assign rolling = cfg_q[IDX_GENERAL][GEN_ROLLING];
	assign prog_gain = {cfg_q[IDX_FINE][11:0], cfg_q[IDX_GAIN][8:5],
		cfg_q[IDX_GAIN][1:0]};

	// write value after masking and range clamps
	always_comb begin
		wval = hwdata[15:0] & FSC_MASK[idx_q];
		if (idx_q == IDX_DARK && wval[7:0] == 8'h00) begin
			wval[7:0] = DARK_MIN;
		end
		if (idx_q == IDX_FILLER && wval[11:0] > FILLER_MAX) begin
			wval[11:0] = FILLER_MAX;
		end
	end

	// status shows which synchronised groups still wait for frame start
	always_comb begin
		status_w = 16'h0000;
		status_w[0] = act_line_q != cfg_q[IDX_READOUT][7:0];
		status_w[1] = {7'h00, act_dark_q} != cfg_q[IDX_DARK];
		status_w[2] = {4'h0, act_fill_q} != cfg_q[IDX_FILLER];
		status_w[3] = act_exp_q[0] != cfg_q[IDX_EXP];
		status_w[5] = {8'h00, act_roi_q} != cfg_q[IDX_REGION];
		status_w[8] = gain_pend_q;
		status_w[9] = gain_wait_q;
	end

	// ahb-lite slave: writes land after the data phase, reads take a wait
	always_comb begin
		wr_d = wr_q;
		rd_d = 1'b0;
		ok_d = ok_q;
		idx_d = idx_q;
		ready_d = 1'b1;
		rdata_d = rdata_q;
		if (ready_q) begin
			wr_d = 1'b0;
			if (accept) begin
				wr_d = hwrite && (hsize == HSIZE_WORD);
				rd_d = !hwrite;
				ok_d = addr_ok(haddr);
				idx_d = haddr[5:2];
				ready_d = hwrite;
			end
		end
		if (rd_q) begin
			rdata_d = 32'h0000_0000;
			if (ok_q && idx_q == IDX_STATUS) begin
				rdata_d[15:0] = status_w;
			end else if (ok_q) begin
				rdata_d[15:0] = cfg_q[idx_q];
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			ok_q <= 1'b0;
			idx_q <= 4'h0;
			ready_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			ok_q <= ok_d;
			idx_q <= idx_d;
			ready_q <= ready_d;
			rdata_q <= rdata_d;
		end
	end

	// programmed registers
	always_comb begin
		cfg_d = cfg_q;
		if (do_write) begin
			cfg_d[idx_q] = wval;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q <= FSC_RST;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// active copies: follow at once or only at frame start
	always_comb begin
		act_line_d = act_line_q;
		act_dark_d = act_dark_q;
		act_fill_d = act_fill_q;
		act_roi_d = act_roi_q;
		act_exp_d = act_exp_q;
		if (!cfg_q[IDX_SYNC][SYNC_LINE] || frame_start) begin
			act_line_d = cfg_q[IDX_READOUT][7:0];
		end
		if (!cfg_q[IDX_SYNC][SYNC_DARK] || frame_start) begin
			act_dark_d = cfg_q[IDX_DARK][8:0];
		end
		if (!cfg_q[IDX_SYNC][SYNC_FILLER] || frame_start) begin
			act_fill_d = cfg_q[IDX_FILLER][11:0];
		end
		if (!cfg_q[IDX_SYNC][SYNC_REGION] || frame_start) begin
			act_roi_d = cfg_q[IDX_REGION][7:0];
		end
		if (!cfg_q[IDX_SYNC][SYNC_EXP] || frame_start) begin
			act_exp_d[0] = cfg_q[IDX_EXP];
			act_exp_d[1] = cfg_q[IDX_EXP2];
			act_exp_d[2] = cfg_q[IDX_EXP3];
		end
	end

	// gain: pending then optionally one more frame of delay
	always_comb begin
		act_gain_d = act_gain_q;
		gain_pend_d = gain_pend_q;
		gain_wait_d = gain_wait_q;
		if (!cfg_q[IDX_SYNC][SYNC_GAIN]) begin
			act_gain_d = prog_gain;
			gain_pend_d = 1'b0;
			gain_wait_d = 1'b0;
		end else begin
			if (frame_start) begin
				if (gain_wait_q) begin
					act_gain_d = prog_gain;
					gain_wait_d = 1'b0;
				end
				if (gain_pend_q) begin
					gain_pend_d = 1'b0;
					if (cfg_q[IDX_GAIN][GAIN_LAT_COMP]) begin
						gain_wait_d = 1'b1;
					end else begin
						act_gain_d = prog_gain;
					end
				end
			end
			// a new write wins over the clear at frame start
			if (do_write && (idx_q == IDX_GAIN || idx_q == IDX_FINE)) begin
				gain_pend_d = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_line_q <= 8'h00;
			act_dark_q <= 9'h102;
			act_fill_q <= 12'h000;
			act_roi_q <= 8'h01;
			act_exp_q <= '{16'h0000, 16'h0000, 16'h0000};
			act_gain_q <= 18'h0203E;
			gain_pend_q <= 1'b0;
			gain_wait_q <= 1'b0;
		end else begin
			act_line_q <= act_line_d;
			act_dark_q <= act_dark_d;
			act_fill_q <= act_fill_d;
			act_roi_q <= act_roi_d;
			act_exp_q <= act_exp_d;
			act_gain_q <= act_gain_d;
			gain_pend_q <= gain_pend_d;
			gain_wait_q <= gain_wait_d;
		end
	end

	// output stage, every output but the constant hresp from a flip-flop
	logic [7:0] gap_d, line_d;
	logic [11:0] fill_d;
	logic [2:0] mon_d;
	logic k2_d, k3_d;
	logic [15:0] per_d, kx2_d, kx3_d;

	always_comb begin
		gap_d = 8'h00;
		if (cfg_q[IDX_GENERAL][GEN_GAP_EN]) begin
			gap_d = cfg_q[IDX_READOUT][15:8];
		end
		line_d = rolling ? act_line_q : 8'h00;
		fill_d = rolling ? act_fill_q : 12'h000;
		k2_d = !rolling && cfg_q[IDX_INTEG][INT_TWO_KNEE];
		k3_d = !rolling && cfg_q[IDX_INTEG][INT_THREE_KNEE];
		per_d = rolling ? 16'h0000 : cfg_q[IDX_PERIOD];
		kx2_d = rolling ? 16'h0000 : act_exp_q[1];
		kx3_d = rolling ? 16'h0000 : act_exp_q[2];
		case (cfg_q[IDX_GENERAL][GEN_MON_LSB +: 3])
			3'h1: mon_d = {frame_start, rolling,
				cfg_q[IDX_GENERAL][GEN_ENABLE]};
			3'h2: mon_d = {gain_wait_q, gain_pend_q, frame_start};
			3'h3: mon_d = {k3_d, k2_d, first_row_blanking};
			3'h4: mon_d = {status_w[3], status_w[1], status_w[0]};
			default: mon_d = 3'h0;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_enable <= 1'b0;
			rolling_shutter_mode <= 1'b0;
			triggered_mode <= 1'b0;
			slave_mode <= 1'b0;
			readout_gap_cycles <= 8'h00;
			subsampling_select <= 1'b0;
			binning_select <= 1'b0;
			exposure_stats_window_enable <= 1'b0;
			monitor_pin_select <= 3'h0;
			monitor_pins <= 3'h0;
			rolling_line_extension <= 8'h00;
			active_region_select <= 8'h01;
			dark_row_count <= 8'h02;
			first_row_blanking <= 1'b1;
			filler_row_count <= 12'h000;
			two_knee_enable <= 1'b0;
			three_knee_enable <= 1'b0;
			period_interpretation_select <= 1'b1;
			exposure_tick_divider <= 16'h0001;
			period_length <= 16'h0000;
			exposure_time <= 16'h0000;
			exposure_in_lines <= 1'b0;
			second_knee_exposure <= 16'h0000;
			third_knee_exposure <= 16'h0000;
			analog_gain_first <= 2'h2;
			analog_gain_second <= 4'hF;
			fine_digital_gain <= 12'h080;
		end else begin
			seq_enable <= cfg_q[IDX_GENERAL][GEN_ENABLE];
			rolling_shutter_mode <= rolling;
			triggered_mode <= cfg_q[IDX_GENERAL][GEN_TRIGGERED];
			slave_mode <= cfg_q[IDX_GENERAL][GEN_SLAVE];
			readout_gap_cycles <= gap_d;
			subsampling_select <= cfg_q[IDX_GENERAL][GEN_SUBSAMPLE];
			binning_select <= cfg_q[IDX_GENERAL][GEN_BINNING];
			exposure_stats_window_enable <=
				cfg_q[IDX_GENERAL][GEN_STATS_WIN];
			monitor_pin_select <= cfg_q[IDX_GENERAL][GEN_MON_LSB +: 3];
			monitor_pins <= mon_d;
			rolling_line_extension <= line_d;
			active_region_select <= act_roi_q;
			dark_row_count <= act_dark_q[7:0];
			first_row_blanking <= act_dark_q[DARK_BLANK];
			filler_row_count <= fill_d;
			two_knee_enable <= k2_d;
			three_knee_enable <= k3_d;
			period_interpretation_select <=
				cfg_q[IDX_INTEG][INT_PERIOD_SEL];
			exposure_tick_divider <= cfg_q[IDX_TICK];
			period_length <= per_d;
			exposure_time <= act_exp_q[0];
			exposure_in_lines <= rolling;
			second_knee_exposure <= kx2_d;
			third_knee_exposure <= kx3_d;
			analog_gain_first <= act_gain_q[1:0];
			analog_gain_second <= act_gain_q[5:2];
			fine_digital_gain <= act_gain_q[17:6];
		end
	end

	assign hreadyout = ready_q;
	assign hrdata = rdata_q;
	assign hresp = 1'b0;

	chk_gap_off_zero: assert property (
		!cfg_q[IDX_GENERAL][GEN_GAP_EN] |=> readout_gap_cycles == 8'h00)
		else $error("readout gap nonzero while disabled");
	chk_gap_value: assert property (
		cfg_q[IDX_GENERAL][GEN_GAP_EN] |=>
		readout_gap_cycles == $past(cfg_q[IDX_READOUT][15:8]))
		else $error("readout gap does not follow field");
	chk_dark_nonzero: assert property (
		##1 dark_row_count != 8'h00)
		else $error("dark row count reached zero");
	chk_filler_range: assert property (
		filler_row_count <= FILLER_MAX)
		else $error("filler row count above range");
	chk_knee_global: assert property (
		rolling |=> !two_knee_enable && !three_knee_enable)
		else $error("knee enabled in rolling shutter");
	chk_line_sync_hold: assert property (
		cfg_q[IDX_SYNC][SYNC_LINE] && !frame_start |=> $stable(act_line_q))
		else $error("line extension changed outside frame start");
	chk_exp_immediate: assert property (
		!cfg_q[IDX_SYNC][SYNC_EXP] |=> act_exp_q[0] == $past(cfg_q[IDX_EXP]))
		else $error("unsynced exposure not applied at once");
	chk_gain_deferral: assert property (
		cfg_q[IDX_SYNC][SYNC_GAIN] && frame_start && gain_pend_q &&
		!gain_wait_q && cfg_q[IDX_GAIN][GAIN_LAT_COMP] |=>
		gain_wait_q && $stable(act_gain_q))
		else $error("gain applied without extra frame");
	chk_read_wait: assert property (
		ready_q && accept && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read did not take one wait state");
endmodule

// [testbench/fsc_regs_test.sv]
// self-checking bench for the sequencer configuration bank
// drives the ahb-lite port and frame_start itself; hready is hreadyout
`timescale 1ns/1ps
module fsc_regs_test;
	import fsc_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, frame_start, rd_dp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, analog_gain_first;
	logic [2:0] hsize, monitor_pins, monitor_pin_select;
	logic hreadyout, hresp, seq_enable, rolling_shutter_mode;
	logic triggered_mode, slave_mode, subsampling_select, binning_select;
	logic exposure_stats_window_enable, first_row_blanking;
	logic two_knee_enable, three_knee_enable, exposure_in_lines;
	logic period_interpretation_select;
	logic [7:0] readout_gap_cycles, rolling_line_extension;
	logic [7:0] active_region_select, dark_row_count;
	logic [11:0] filler_row_count, fine_digital_gain;
	logic [15:0] exposure_tick_divider, period_length, exposure_time;
	logic [15:0] second_knee_exposure, third_knee_exposure, d;
	logic [3:0] analog_gain_second;
	logic [31:0] exp_q[$];
	logic r;
	int fails, samples_checked, cycles;

	assign hready = hreadyout;

	fsc_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .frame_start(frame_start),
		.seq_enable(seq_enable), .rolling_shutter_mode(rolling_shutter_mode),
		.triggered_mode(triggered_mode), .slave_mode(slave_mode),
		.readout_gap_cycles(readout_gap_cycles),
		.subsampling_select(subsampling_select),
		.binning_select(binning_select),
		.exposure_stats_window_enable(exposure_stats_window_enable),
		.monitor_pin_select(monitor_pin_select),
		.monitor_pins(monitor_pins),
		.rolling_line_extension(rolling_line_extension),
		.active_region_select(active_region_select),
		.dark_row_count(dark_row_count),
		.first_row_blanking(first_row_blanking),
		.filler_row_count(filler_row_count),
		.two_knee_enable(two_knee_enable),
		.three_knee_enable(three_knee_enable),
		.period_interpretation_select(period_interpretation_select),
		.exposure_tick_divider(exposure_tick_divider),
		.period_length(period_length), .exposure_time(exposure_time),
		.exposure_in_lines(exposure_in_lines),
		.second_knee_exposure(second_knee_exposure),
		.third_knee_exposure(third_knee_exposure),
		.analog_gain_first(analog_gain_first),
		.analog_gain_second(analog_gain_second),
		.fine_digital_gain(fine_digital_gain));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		samples_checked++;
		if (seen !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
		end
	endtask

	task stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 6000) begin
			fails++;
			stop_test;
		end
	end

	// read data are compared at the edge that ends the data phase
	always @(posedge hclk) begin
		if (rd_dp === 1'b1 && hreadyout === 1'b1) begin
			rd_dp <= 1'b0;
			chk("hresp", 32'(hresp), 32'h0);
			chk("hrdata", hrdata, exp_q.pop_front());
		end
	end

	// one single transfer; for reads dd is the expected word
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] dd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= w ? dd : 32'h0;
		if (!w) begin
			exp_q.push_back(dd);
			rd_dp <= 1'b1;
		end
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task wr(input logic [3:0] i, input logic [15:0] v);
		xfer(1'b1, {26'h0, i, 2'b00}, {16'h0, v});
	endtask

	task rd(input logic [3:0] i, input logic [15:0] v);
		xfer(1'b0, {26'h0, i, 2'b00}, {16'h0, v});
	endtask

	task settle;
		repeat (2) @(posedge hclk);
		#1;
	endtask

	task frame;
		@(posedge hclk);
		frame_start <= 1'b1;
		@(posedge hclk);
		frame_start <= 1'b0;
		settle;
	endtask

	function automatic logic [15:0] expv(input logic [3:0] i,
		input logic [15:0] v);
		logic [15:0] x;
		x = v & FSC_MASK[i];
		if (i == IDX_DARK && x[7:0] == 8'h00)
			x[7:0] = DARK_MIN;
		if (i == IDX_FILLER && x[11:0] > FILLER_MAX)
			x[11:0] = FILLER_MAX;
		return x;
	endfunction

	// outputs that must show their reset values
	task chk_dflt;
		chk("dark", 32'(dark_row_count), 32'h2);
		chk("blank", 32'(first_row_blanking), 32'h1);
		chk("psel", 32'(period_interpretation_select), 32'h1);
		chk("tick", 32'(exposure_tick_divider), 32'h1);
		chk("subs", 32'(subsampling_select), 32'h0);
		chk("bin", 32'(binning_select), 32'h0);
		chk("g1", 32'(analog_gain_first), 32'h2);
		chk("g2", 32'(analog_gain_second), 32'hF);
		chk("fine", 32'(fine_digital_gain), 32'h080);
		chk("roi", 32'(active_region_select), 32'h01);
		chk("en", 32'(seq_enable), 32'h0);
		chk("trig", 32'(triggered_mode), 32'h0);
		chk("slave", 32'(slave_mode), 32'h0);
		chk("roll", 32'(rolling_shutter_mode), 32'h0);
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		frame_start = 1'b0;
		rd_dp = 1'b0;
		fails = 0;
		samples_checked = 0;
		cycles = 0;
		void'($urandom(32'hB9BE));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < FSC_NREG; i++)
			rd(i[3:0], FSC_RST[i]);
		settle;
		chk_dflt;
		$display("test reset done");
		for (int i = 0; i < FSC_NREG; i++) begin
			d = 16'($urandom());
			wr(i[3:0], d);
			rd(i[3:0], expv(i[3:0], d));
		end
		wr(IDX_DARK, 16'h0100);
		rd(IDX_DARK, 16'h0101);
		wr(IDX_FILLER, 16'h0FFF);
		rd(IDX_FILLER, 16'h07FF);
		$display("test access done");
		wr(IDX_SYNC, 16'h0000);
		wr(IDX_READOUT, 16'hA53C);
		wr(IDX_INTEG, 16'h0003);
		wr(IDX_DARK, 16'h0105);
		wr(IDX_FILLER, 16'h0123);
		wr(IDX_PERIOD, 16'h4321);
		wr(IDX_EXP, 16'h0055);
		wr(IDX_EXP2, 16'h1111);
		wr(IDX_EXP3, 16'h2222);
		wr(IDX_GAIN, 16'h0000);
		wr(IDX_FINE, 16'h0100);
		for (int m = 0; m < 2; m++) begin
			r = m[0];
			wr(IDX_GENERAL, r ? 16'h0002 : 16'h1DF1);
			settle;
			chk("gap", 32'(readout_gap_cycles), r ? 32'h0 : 32'hA5);
			chk("subs", 32'(subsampling_select), 32'(!r));
			chk("bin", 32'(binning_select), 32'(!r));
			chk("win", 32'(exposure_stats_window_enable), 32'(!r));
			chk("msel", 32'(monitor_pin_select), r ? 32'h0 : 32'h3);
			chk("mpin", 32'(monitor_pins), r ? 32'h0 : 32'h7);
			chk("lext", 32'(rolling_line_extension), r ? 32'h3C : 32'h0);
			chk("k2", 32'(two_knee_enable), 32'(!r));
			chk("k3", 32'(three_knee_enable), 32'(!r));
			chk("psel", 32'(period_interpretation_select), 32'h0);
			chk("dark", 32'(dark_row_count), 32'h5);
			chk("blank", 32'(first_row_blanking), 32'h1);
			chk("fill", 32'(filler_row_count), r ? 32'h123 : 32'h0);
			chk("per", 32'(period_length), r ? 32'h0 : 32'h4321);
			chk("lines", 32'(exposure_in_lines), 32'(r));
			chk("exp", 32'(exposure_time), 32'h55);
			chk("roll", 32'(rolling_shutter_mode), 32'(r));
			chk("en", 32'(seq_enable), 32'(!r));
			chk("trig", 32'(triggered_mode), 32'(!r));
			chk("slave", 32'(slave_mode), 32'(!r));
			chk("e2", 32'(second_knee_exposure), r ? 32'h0 : 32'h1111);
			chk("e3", 32'(third_knee_exposure), r ? 32'h0 : 32'h2222);
		end
		$display("test modes done");
		xfer(1'b1, 32'h40, 32'hFFFF);
		rd(IDX_GENERAL, 16'h0002);
		xfer(1'b0, 32'h40, 32'h0);
		xfer(1'b0, 32'h1, 32'h0);
		$display("test unmapped done");
		wr(IDX_GENERAL, 16'h2002);
		wr(IDX_SYNC, 16'h033F);
		wr(IDX_EXP, 16'h0777);
		wr(IDX_DARK, 16'h0109);
		wr(IDX_READOUT, 16'h0099);
		settle;
		chk("exp", 32'(exposure_time), 32'h55);
		chk("dark", 32'(dark_row_count), 32'h5);
		chk("lext", 32'(rolling_line_extension), 32'h3C);
		chk("mpin", 32'(monitor_pins), 32'h7);
		rd(IDX_STATUS, 16'h000B);
		frame;
		chk("exp", 32'(exposure_time), 32'h777);
		chk("dark", 32'(dark_row_count), 32'h9);
		chk("lext", 32'(rolling_line_extension), 32'h99);
		chk("mpin", 32'(monitor_pins), 32'h0);
		rd(IDX_STATUS, 16'h0000);
		$display("test sync done");
		wr(IDX_GENERAL, 16'h1002);
		wr(IDX_GAIN, 16'h2061);
		settle;
		chk("mpin", 32'(monitor_pins), 32'h2);
		frame;
		chk("g1", 32'(analog_gain_first), 32'h0);
		chk("mpin", 32'(monitor_pins), 32'h4);
		frame;
		chk("g1", 32'(analog_gain_first), 32'h1);
		chk("g2", 32'(analog_gain_second), 32'h3);
		wr(IDX_GAIN, 16'h0042);
		wr(IDX_FINE, 16'h0200);
		frame;
		chk("g1", 32'(analog_gain_first), 32'h2);
		chk("g2", 32'(analog_gain_second), 32'h2);
		chk("fine", 32'(fine_digital_gain), 32'h200);
		$display("test gain done");
		wr(IDX_GENERAL, 16'h0803);
		settle;
		chk("mpin", 32'(monitor_pins), 32'h3);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(IDX_GAIN, 16'h01E2);
		settle;
		chk_dflt;
		$display("test reset again done");
		@(posedge hclk);
		stop_test;
	end
endmodule
